// *** core/usrd_top.sv ***
// Receive status, control and data registers of the serial interface, APB slave
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "usrd_regs.svh"

module usrd_top
    import usrd_pkg::*;
#(
    parameter int ADDR_W = 5
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic             ce,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             rxFrameValid,
    input  wire usrd_rxframe_type rxFrame,
    input  wire logic             startSlotLow,
    input  wire logic             idleDetect,
    output logic                  rxReady,
    input  wire logic             rxPinIn,
    output logic                  rxLineOut,
    input  wire logic             txLineIn,
    output logic                  txPinOut,
    output logic                  txPinOe,
    output logic                  txLoad,
    output logic      [8:0]       txFrame,
    output logic                  longBreak,
    output logic                  nineBitMode,
    output logic      [12:0]      baudDivisor
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (ADDR_W < 5) begin : g_addr_check
        $error("ADDR_W must be at least 5");
    end

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Even type wants the xor of data and parity bit to be zero
    function automatic logic parityBad(
        input logic [8:0] bits,
        input logic       nine,
        input logic       odd
    );
        logic p;
        p = nine ? ^bits : ^bits[7:0];
        return p ^ odd;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    usrd_apb_state_type apbState_r;
    logic [31:0]        prdata_r;
    logic               pready_r;
    logic               pslverr_r;
    logic [7:0]         baudHi_r;
    logic [7:0]         baudLo_r;
    logic [7:0]         ctl1_r;
    logic [7:0]         altStat1_r;
    logic [7:0]         altCtl1_r;
    logic [7:0]         altCtl2_r;
    logic [7:0]         stat2_r;
    logic               active_r;
    logic               rxFull_r;
    usrd_err_type       err_r;
    logic [4:0]         arm_r;
    logic [8:0]         rxData_r;
    logic               txNinth_r;
    logic [8:0]         txFrame_r;
    logic               txLoad_r;
    logic               txPinOut_r;
    logic               txPinOe_r;
    logic               rxLineOut_r;
    logic               rxReady_r;
    logic               framing_nxt;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic [2:0] idx;
    logic       mapped;
    logic       xfer;
    logic       wrEn;
    logic       rdEn;
    logic       altMap;
    logic       stat1Rd;
    logic       dataLoRd;
    logic       dataLoWr;
    logic       dataHiWr;

    assign idx    = paddr[4:2];
    assign altMap = stat2_r[`USRD_S2_MAPSEL];
    assign mapped = (paddr[1:0] == 2'h0) && (idx != `USRD_IDX_NONE)
                    && ((paddr >> 5) == '0);
    assign xfer   = ce && (apbState_r == USRD_ACCESS) && psel && penable;
    assign wrEn   = xfer && pwrite && mapped;
    assign rdEn   = xfer && !pwrite && mapped;
    assign stat1Rd  = rdEn && (idx == `USRD_IDX_STAT1);
    assign dataLoRd = rdEn && (idx == `USRD_IDX_DATALO);
    assign dataLoWr = wrEn && (idx == `USRD_IDX_DATALO);
    assign dataHiWr = wrEn && (idx == `USRD_IDX_DATAHI);

    // Status one image, as software sees it
    logic [7:0] stat1Img;
    always_comb begin
        stat1Img                     = `USRD_RESET_BYTE;
        stat1Img[`USRD_S1_RXFULL]    = rxFull_r;
        stat1Img[`USRD_S1_OVR]       = err_r.overrun;
        stat1Img[`USRD_S1_NOISE]     = err_r.noise;
        stat1Img[`USRD_S1_FRAMING]   = err_r.framing;
        stat1Img[`USRD_S1_PARITY]    = err_r.parity;
    end

    logic [7:0] rdByte;
    always_comb begin
        rdByte = `USRD_RESET_BYTE;
        unique case (idx)
            `USRD_IDX_BAUDHI: rdByte = altMap ? altStat1_r : baudHi_r;
            `USRD_IDX_BAUDLO: rdByte = altMap ? altCtl1_r : baudLo_r;
            `USRD_IDX_CTL1:   rdByte = altMap ? altCtl2_r : ctl1_r;
            `USRD_IDX_NONE:   rdByte = `USRD_RESET_BYTE;
            `USRD_IDX_STAT1:  rdByte = stat1Img;
            `USRD_IDX_STAT2: begin
                rdByte                    = stat2_r;
                rdByte[`USRD_S2_ACTIVE]   = active_r;
            end
            `USRD_IDX_DATAHI: begin
                rdByte                    = `USRD_RESET_BYTE;
                rdByte[`USRD_DH_RXNINTH]  = rxData_r[8];
                rdByte[`USRD_DH_TXNINTH]  = txNinth_r;
            end
            `USRD_IDX_DATALO: rdByte = rxData_r[7:0];
        endcase
    end

    // ------------------------------------------------------------
    // APB slave: one setup, one access cycle with pready high
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            apbState_r <= USRD_SETUP;
            prdata_r   <= 32'h0000_0000;
            pready_r   <= 1'b0;
            pslverr_r  <= 1'b0;
        end else if (ce) begin
            unique case (apbState_r)
                USRD_SETUP: begin
                    if (psel && !penable) begin
                        prdata_r   <= (mapped && !pwrite) ? {24'h00_0000, rdByte}
                                                          : 32'h0000_0000;
                        pslverr_r  <= !mapped;
                        pready_r   <= 1'b1;
                        apbState_r <= USRD_ACCESS;
                    end
                end
                USRD_ACCESS: begin
                    if (psel && penable) begin
                        pready_r   <= 1'b0;
                        pslverr_r  <= 1'b0;
                        apbState_r <= USRD_SETUP;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            baudHi_r   <= `USRD_RESET_BYTE;
            baudLo_r   <= `USRD_BAUDLO_RESET;
            ctl1_r     <= `USRD_RESET_BYTE;
            altStat1_r <= `USRD_RESET_BYTE;
            altCtl1_r  <= `USRD_RESET_BYTE;
            altCtl2_r  <= `USRD_RESET_BYTE;
            stat2_r    <= `USRD_RESET_BYTE;
        end else if (wrEn) begin
            unique case (idx)
                `USRD_IDX_BAUDHI: begin
                    if (altMap) altStat1_r <= pwdata[7:0];
                    else baudHi_r <= pwdata[7:0];
                end
                `USRD_IDX_BAUDLO: begin
                    if (altMap) altCtl1_r <= pwdata[7:0];
                    else baudLo_r <= pwdata[7:0];
                end
                `USRD_IDX_CTL1: begin
                    if (altMap) altCtl2_r <= pwdata[7:0];
                    else ctl1_r <= pwdata[7:0];
                end
                `USRD_IDX_STAT2: stat2_r <= pwdata[7:0] & `USRD_S2_WMASK;
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Receive flags and buffer
    // ------------------------------------------------------------
    logic accept;
    logic lost;
    logic [4:0] clrMask;

    // A frame arriving while framing is flagged is simply ignored
    assign accept  = ce && rxFrameValid && !err_r.framing
                     && !rxFull_r && !err_r.overrun;
    assign lost    = ce && rxFrameValid && !err_r.framing
                     && (rxFull_r || err_r.overrun);
    assign clrMask = dataLoRd ? arm_r : 5'h00;

    // Arming uses the snapshot software actually read
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            arm_r <= 5'h00;
        end else if (stat1Rd) begin
            arm_r <= arm_r | {prdata_r[`USRD_S1_RXFULL], prdata_r[3:0]};
        end else if (dataLoRd) begin
            arm_r <= 5'h00;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rxFull_r <= 1'b0;
        end else if (accept) begin
            rxFull_r <= 1'b1;
        end else if (clrMask[4]) begin
            rxFull_r <= 1'b0;
        end
    end

    // Set wins over a clear in the same cycle; a stale overrun stays
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            err_r <= '0;
        end else if (ce) begin
            if (lost) err_r.overrun <= 1'b1;
            else if (clrMask[3]) err_r.overrun <= 1'b0;
            if (accept && rxFrame.noise) err_r.noise <= 1'b1;
            else if (clrMask[2]) err_r.noise <= 1'b0;
            if (accept && !rxFrame.stopBit) err_r.framing <= 1'b1;
            else if (clrMask[1]) err_r.framing <= 1'b0;
            if (accept && ctl1_r[`USRD_C1_PAREN]
                && parityBad(rxFrame.bits, ctl1_r[`USRD_C1_NINE],
                             ctl1_r[`USRD_C1_PARODD])) begin
                err_r.parity <= 1'b1;
            end else if (clrMask[0]) begin
                err_r.parity <= 1'b0;
            end
        end
    end

    // Overrun leaves the held frame untouched
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rxData_r <= 9'h000;
        end else if (accept) begin
            rxData_r <= {ctl1_r[`USRD_C1_NINE] & rxFrame.bits[8],
                         rxFrame.bits[7:0]};
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            active_r <= 1'b0;
        end else if (ce) begin
            if (startSlotLow) active_r <= 1'b1;
            else if (idleDetect) active_r <= 1'b0;
        end
    end

    assign framing_nxt = (accept && !rxFrame.stopBit)
                         || (err_r.framing && !clrMask[1]);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rxReady_r <= 1'b1;
        end else if (ce) begin
            rxReady_r <= !framing_nxt;
        end
    end

    // ------------------------------------------------------------
    // Transmit buffer
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            txNinth_r <= 1'b0;
        end else if (dataHiWr) begin
            txNinth_r <= pwdata[`USRD_DH_TXNINTH];
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            txFrame_r <= 9'h000;
            txLoad_r  <= 1'b0;
        end else if (ce) begin
            txLoad_r <= dataLoWr;
            if (dataLoWr) begin
                txFrame_r <= {txNinth_r & ctl1_r[`USRD_C1_NINE],
                              pwdata[7:0]};
            end
        end
    end

    // ------------------------------------------------------------
    // Line polarity and pin direction
    // ------------------------------------------------------------
    // Registered to keep outputs glitch free; costs one cycle of skew
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            txPinOut_r  <= 1'b1;
            rxLineOut_r <= 1'b1;
            txPinOe_r   <= 1'b1;
        end else if (ce) begin
            txPinOut_r  <= txLineIn ^ stat2_r[`USRD_S2_TXINV];
            rxLineOut_r <= rxPinIn ^ stat2_r[`USRD_S2_RXINV];
            txPinOe_r   <= !ctl1_r[`USRD_C1_SWIRE]
                           || stat2_r[`USRD_S2_SINGLE_WIRE_TX_DIRECTION];
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata      = prdata_r;
    assign pready      = pready_r;
    assign pslverr     = pslverr_r;
    assign rxReady     = rxReady_r;
    assign rxLineOut   = rxLineOut_r;
    assign txPinOut    = txPinOut_r;
    assign txPinOe     = txPinOe_r;
    assign txLoad      = txLoad_r;
    assign txFrame     = txFrame_r;
    assign longBreak   = stat2_r[`USRD_S2_LONGBRK];
    assign nineBitMode = ctl1_r[`USRD_C1_NINE];
    assign baudDivisor = {baudHi_r[4:0], baudLo_r};

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    property p_overrun_set;
        lost |=> err_r.overrun && $stable(rxData_r);
    endproperty
    a_overrun_set: assert property (p_overrun_set)
        else $error("overrun not flagged or buffer changed");

    property p_noise_clear;
        $fell(err_r.noise) |-> $past(dataLoRd);
    endproperty
    a_noise_clear: assert property (p_noise_clear)
        else $error("noise flag cleared without data read");

    property p_overrun_held;
        (err_r.overrun && !$past(stat1Rd) && !arm_r[3] && dataLoRd)
            |=> err_r.overrun;
    endproperty
    a_overrun_held: assert property (p_overrun_held)
        else $error("unarmed overrun cleared");

    property p_noise_with_full;
        $rose(err_r.noise) |-> $rose(rxFull_r);
    endproperty
    a_noise_with_full: assert property (p_noise_with_full)
        else $error("noise set apart from receive full");

    property p_framing_set;
        (accept && !rxFrame.stopBit) |=> err_r.framing ##0 !rxReady;
    endproperty
    a_framing_set: assert property (p_framing_set)
        else $error("framing error missed");

    property p_framing_block;
        (err_r.framing && rxFrameValid) |=> $stable(rxData_r) && !err_r.overrun[*1];
    endproperty
    a_framing_block: assert property (p_framing_block)
        else $error("frame taken while framing flagged");

    property p_parity_set;
        (accept && ctl1_r[`USRD_C1_PAREN]
         && parityBad(rxFrame.bits, ctl1_r[`USRD_C1_NINE], ctl1_r[`USRD_C1_PARODD]))
            |=> err_r.parity && rxFull_r;
    endproperty
    a_parity_set: assert property (p_parity_set)
        else $error("parity error missed");

    property p_active;
        (ce && (startSlotLow || idleDetect)) |=> (active_r == $past(startSlotLow));
    endproperty
    a_active: assert property (p_active)
        else $error("receiver active flag wrong");

    property p_tx_ninth;
        (dataLoWr && ctl1_r[`USRD_C1_NINE]) |=> txLoad && txFrame[8] == $past(txNinth_r);
    endproperty
    a_tx_ninth: assert property (p_tx_ninth)
        else $error("ninth bit not sent");

    property p_stat1_ro;
        (wrEn && idx == `USRD_IDX_STAT1 && !rxFrameValid) |=> $stable(err_r);
    endproperty
    a_stat1_ro: assert property (p_stat1_ro)
        else $error("status one write changed flags");

endmodule

// *** inc/usrd_regs.svh ***
// Register indices, field positions and reset values of the receive status and data block
`ifndef USRD_REGS_SVH
`define USRD_REGS_SVH

// Register indices; byte address is four times the index
`define USRD_IDX_BAUDHI   3'h0
`define USRD_IDX_BAUDLO   3'h1
`define USRD_IDX_CTL1     3'h2
`define USRD_IDX_NONE     3'h3
`define USRD_IDX_STAT1    3'h4
`define USRD_IDX_STAT2    3'h5
`define USRD_IDX_DATAHI   3'h6
`define USRD_IDX_DATALO   3'h7

// Status one fields
`define USRD_S1_RXFULL    5
`define USRD_S1_OVR       3
`define USRD_S1_NOISE     2
`define USRD_S1_FRAMING   1
`define USRD_S1_PARITY    0

// Status two fields
`define USRD_S2_MAPSEL    7
`define USRD_S2_TXINV     4
`define USRD_S2_RXINV     3
`define USRD_S2_LONGBRK   2
`define USRD_S2_SINGLE_WIRE_TX_DIRECTION     1
`define USRD_S2_ACTIVE    0
`define USRD_S2_WMASK     8'h9E

// Control one fields
`define USRD_C1_SWIRE     5
`define USRD_C1_NINE      4
`define USRD_C1_PAREN     1
`define USRD_C1_PARODD    0

// Data high fields
`define USRD_DH_RXNINTH   7
`define USRD_DH_TXNINTH   6

`define USRD_RESET_BYTE   8'h00
`define USRD_BAUDLO_RESET 8'h04

`endif

// *** inc/usrd_pkg.sv ***
// Types shared by the receive status and data block
package usrd_pkg;

    typedef struct packed {
        logic [8:0] bits;
        logic       stopBit;
        logic       noise;
    } usrd_rxframe_type;

    typedef struct packed {
        logic       overrun;
        logic       noise;
        logic       framing;
        logic       parity;
    } usrd_err_type;

    typedef enum logic {
        USRD_SETUP,
        USRD_ACCESS
    } usrd_apb_state_type;

endpackage

// *** verification/usrd_far_node.sv ***
// Far-side receiver front end: start detect, completed frames, idle detect
`timescale 1ns/1ps

module usrd_far_node
    import usrd_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic             go,
    input  wire logic [8:0]       bits,
    input  wire logic             stopBit,
    input  wire logic             noise,
    output logic                  rxFrameValid,
    output usrd_rxframe_type      rxFrame,
    output logic                  startSlotLow,
    output logic                  idleDetect
);
    logic [4:0] idleCnt;
    logic       goDly;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            {rxFrameValid, startSlotLow, idleDetect, goDly} <= '0;
            rxFrame <= '0;
            idleCnt <= '0;
        end else begin
            goDly        <= go;
            startSlotLow <= go;
            rxFrameValid <= goDly;
            // Frame lines only meaningful with the pulse; toggled otherwise
            rxFrame <= goDly ? {bits, stopBit, noise} : ~rxFrame;
            idleCnt <= goDly ? 5'h10 : (idleCnt != 5'h00 ? idleCnt - 5'h01 : idleCnt);
            idleDetect <= (idleCnt == 5'h01);
        end
    end
endmodule

// *** verification/uart_rx_status_and_data_regs_bench.sv ***
// Register-level tests of the receive status and data block
`timescale 1ns/1ps
`include "usrd_regs.svh"
`define CHK(n, e, g) begin cmpCount++; if ((g) !== (e)) begin badCount++; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); end end

module uart_rx_status_and_data_regs_bench
    import usrd_pkg::*;
;
    logic clock, reset, psel, penable, pwrite, pready, pslverr, rxFrameValid;
    logic startSlotLow, idleDetect, rxReady, rxPinIn, rxLineOut, txLineIn;
    logic txPinOut, txPinOe, txLoad, longBreak, nineBitMode, go, stopBit, noise;
    logic [4:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [8:0] txFrame, bits;
    logic [12:0] baudDivisor;
    logic [7:0] rd;
    logic er;
    usrd_rxframe_type rxFrame;
    int badCount, cmpCount, loadCnt;

    usrd_top DUT (.clock(clock), .reset(reset), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rxFrameValid(rxFrameValid), .rxFrame(rxFrame), .startSlotLow(startSlotLow),
        .idleDetect(idleDetect), .rxReady(rxReady), .rxPinIn(rxPinIn),
        .rxLineOut(rxLineOut), .txLineIn(txLineIn), .txPinOut(txPinOut),
        .txPinOe(txPinOe), .txLoad(txLoad), .txFrame(txFrame), .longBreak(longBreak),
        .nineBitMode(nineBitMode), .baudDivisor(baudDivisor));

    usrd_far_node farNode (.clock(clock), .reset(reset), .go(go), .bits(bits),
        .stopBit(stopBit), .noise(noise), .rxFrameValid(rxFrameValid),
        .rxFrame(rxFrame), .startSlotLow(startSlotLow), .idleDetect(idleDetect));

    // ----------------------------------------
    // Clock, load counter, bus tasks
    // ----------------------------------------
    initial begin
        clock = 0;
        forever #4 clock = ~clock;
    end

    always @(posedge clock) if (txLoad === 1'b1) loadCnt++;

    // Holds the request until pready is seen high; data taken at that edge
    task automatic apb(input logic w, input logic [2:0] idx, input logic [7:0] wd);
        @(posedge clock);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge clock);
        penable <= 1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata[7:0];
        er = pslverr;
        psel <= 0; penable <= 0;
    endtask

    task automatic rdChk(input logic [2:0] idx, input logic [7:0] e);
        apb(0, idx, 8'h00);
        `CHK("read", e, rd)
    endtask

    task automatic send(input logic [8:0] b, input logic s, input logic ns);
        @(posedge clock);
        go <= 1; bits <= b; stopBit <= s; noise <= ns;
        @(posedge clock);
        go <= 0;
        repeat (3) @(posedge clock);
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmpCount, badCount);
        if (badCount == 0 && cmpCount > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        badCount++;
        conclude;
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        {psel, penable, pwrite, go, stopBit, noise, rxPinIn, txLineIn} = '0;
        {paddr, pwdata, bits} = '0;
        reset = 1;
        repeat (20) @(posedge clock);
        reset <= 0;
        `CHK("divisor", 13'h0004, baudDivisor)
        apb(0, `USRD_IDX_NONE, 8'h00);
        `CHK("unmapped", 1'b1, er)
        apb(1, `USRD_IDX_STAT1, 8'hFF);
        rdChk(`USRD_IDX_STAT1, 8'h00);
        // Line controls in status two
        txLineIn <= 1; rxPinIn <= 1;
        apb(1, `USRD_IDX_STAT2, 8'h1E);
        rdChk(`USRD_IDX_STAT2, 8'h1E);
        `CHK("brk", 1'b1, longBreak)
        `CHK("tx_polarity_invert", 1'b0, txPinOut)
        `CHK("rx_polarity_invert", 1'b0, rxLineOut)
        `CHK("oe", 1'b1, txPinOe)
        apb(1, `USRD_IDX_CTL1, 8'h20);
        apb(1, `USRD_IDX_STAT2, 8'h1C);
        // Pin enable is registered behind the register write
        repeat (2) @(posedge clock);
        `CHK("oe sw", 1'b0, txPinOe)
        apb(1, `USRD_IDX_STAT2, 8'h00);
        apb(1, `USRD_IDX_CTL1, 8'h00);
        `CHK("txnorm", 1'b1, txPinOut)
        `CHK("rxnorm", 1'b1, rxLineOut)
        // Alternate map hides baud low
        apb(1, `USRD_IDX_STAT2, 8'h80);
        apb(1, `USRD_IDX_BAUDLO, 8'h55);
        rdChk(`USRD_IDX_BAUDLO, 8'h55);
        apb(1, `USRD_IDX_STAT2, 8'h00);
        rdChk(`USRD_IDX_BAUDLO, 8'h04);
        // Plain receive
        send(9'h0A5, 1, 0);
        rdChk(`USRD_IDX_STAT2, 8'h01);
        rdChk(`USRD_IDX_STAT1, 8'h20);
        rdChk(`USRD_IDX_DATALO, 8'hA5);
        rdChk(`USRD_IDX_STAT1, 8'h00);
        // Overrun after the arming read
        send(9'h011, 1, 0);
        rdChk(`USRD_IDX_STAT1, 8'h20);
        send(9'h022, 1, 0);
        rdChk(`USRD_IDX_DATALO, 8'h11);
        rdChk(`USRD_IDX_STAT1, 8'h08);
        send(9'h033, 1, 0);
        apb(0, `USRD_IDX_DATALO, 8'h00);
        rdChk(`USRD_IDX_STAT1, 8'h00);
        repeat (20) @(posedge clock);
        rdChk(`USRD_IDX_STAT2, 8'h00);
        // Parity, noise, framing together; framing blocks reception
        apb(1, `USRD_IDX_CTL1, 8'h02);
        send(9'h001, 0, 1);
        `CHK("rxReady", 1'b0, rxReady)
        send(9'h0FF, 1, 0);
        rdChk(`USRD_IDX_STAT1, 8'h27);
        rdChk(`USRD_IDX_DATALO, 8'h01);
        rdChk(`USRD_IDX_STAT1, 8'h00);
        `CHK("rxReady", 1'b1, rxReady)
        // Nine-bit receive and transmit
        apb(1, `USRD_IDX_CTL1, 8'h10);
        @(posedge clock);
        `CHK("nine", 1'b1, nineBitMode)
        send(9'h1C3, 1, 0);
        apb(0, `USRD_IDX_DATAHI, 8'h00);
        `CHK("rx9", 1'b1, rd[7])
        rdChk(`USRD_IDX_DATALO, 8'hC3);
        apb(1, `USRD_IDX_DATAHI, 8'hC0);
        apb(1, `USRD_IDX_DATALO, 8'h5A);
        @(posedge clock);
        `CHK("tx9", 9'h15A, txFrame)
        apb(1, `USRD_IDX_DATALO, 8'h33);
        @(posedge clock);
        `CHK("tx9 kept", 9'h133, txFrame)
        apb(1, `USRD_IDX_CTL1, 8'h00);
        apb(1, `USRD_IDX_DATALO, 8'h77);
        @(posedge clock);
        `CHK("tx8", 9'h077, txFrame)
        // Load pulse is counted one edge after it shows
        @(posedge clock);
        `CHK("loads", 3, loadCnt)
        conclude;
    end
endmodule
